/* core/sxmem_timing_consts.svh */
/*
 Constants for the synchronous static memory timing block: register
 addresses, reset and write masks, latency codes, width masks and link
 command codes. Assumes inclusion by bare name from the core folder.
*/
`ifndef SXMEM_TIMING_CONSTS_SVH
`define SXMEM_TIMING_CONSTS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define REG_CONFIG_ADDR 32'h4800001c
`define REG_CTRL_ADDR 32'h48000020
`define REG_REQUEST_ADDR 32'h48000024
`define REG_STATUS_ADDR 32'h48000028
`define REG_RDATA_ADDR 32'h4800002c
`define CONFIG_RESET 32'h00000000
`define CONFIG_WMASK 32'h00007fff

// ----------------------------------------------------------------------
// Field codes
// ----------------------------------------------------------------------
`define TYPE_MASK_ROM 2'h0
`define TYPE_FLASH 2'h2
`define ROWL_CODE_LONG 3'h7
`define ROWL_CODE_RSVD 3'h6
`define ROWL_LONG_CYC 4'h8
`define ROWL_FLASH_CYC 4'h1
`define CASL_MIN_CODE 3'h2
`define CASL_ROM_RSVD 3'h6
`define CASL_FLASH_RSVD 3'h7
`define ROWW_12 2'h0
`define ROWW_13 2'h1
`define ROW_MASK_12 13'h0fff
`define ROW_MASK_13 13'h1fff
`define COL_MASK_7 10'h07f
`define COL_MASK_8 10'h0ff
`define COL_MASK_9 10'h1ff
`define COL_MASK_10 10'h3ff
`define SYNC_LAG_CYC 2'h2
`define CMD_NOP 2'h0
`define CMD_ACT 2'h1
`define CMD_READ 2'h2

`endif

/* core/sxmem_timing_pkg.sv */
/*
 Types for the synchronous static memory timing block: config word
 layout, request word, status word, link request and link states.
 Assumes nothing of its surroundings.
*/
package sxmem_timing_pkg;

    // Config word of pair 0/1, msb first
    typedef struct packed {
        logic [16:0] rsvd;
        logic latch_select;
        logic [1:0] memory_type;
        logic [1:0] column_width;
        logic [1:0] row_width;
        logic [2:0] row_latency;
        logic [2:0] cas_latency;
        logic [1:0] partition_enable;
    } cfg_t;

    // Software read request word
    typedef struct packed {
        logic [7:0] rsvd;
        logic part;
        logic [9:0] col;
        logic [12:0] row;
    } req_word_t;

    // Status word
    typedef struct packed {
        logic [27:0] rsvd;
        logic rl_warn;
        logic err;
        logic done;
        logic busy;
    } status_t;

    // Decoded request handed to the link domain
    typedef struct packed {
        logic half;
        logic part;
        logic [3:0] row_cyc;
        logic [3:0] cas_cyc;
        logic [12:0] row;
        logic [9:0] col;
    } mem_req_t;

    typedef enum logic [2:0] {L_IDLE, L_ACT, L_ROW_WAIT, L_CAS_WAIT, L_CAPT, L_DONE} link_state_t;

endpackage

/* core/sync_static_mem_timing_cfg.sv */
/*
 Timing and geometry configuration for partition pair 0/1 with a small
 read engine that applies it on the memory link. Assumes an APB master
 on CLK_SYS and the memory clock on LINK_CLK, unrelated in phase.
*/
// The APB register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "sxmem_timing_consts.svh"

module sync_static_mem_timing_cfg #(
    parameter int DQ_W = 32
) (
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic LINK_CLK,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic [1:0] MEM_CMD,
    output logic [12:0] MEM_ADDR,
    output logic [1:0] MEM_CS_N,
    output logic MEM_CLK_HALF,
    input wire logic [DQ_W-1:0] MEM_DQ
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (DQ_W < 1 || DQ_W > 32) begin : g_bad_width
        $error("DQ_W must lie between 1 and 32");
    end

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    // Reserved codes refuse the request, except a Flash row latency code, which is not checked
    function automatic logic cfg_ok(sxmem_timing_pkg::cfg_t c, logic part);
        logic ok;
        ok = c.partition_enable[part];
        ok = ok & (c.row_width == `ROWW_12 || c.row_width == `ROWW_13);
        unique case (c.memory_type)
            `TYPE_MASK_ROM: begin
                ok = ok & (c.row_latency != `ROWL_CODE_RSVD);
                ok = ok & (c.cas_latency >= `CASL_MIN_CODE) & (c.cas_latency != `CASL_ROM_RSVD);
            end
            `TYPE_FLASH: begin
                ok = ok & (c.cas_latency >= `CASL_MIN_CODE) & (c.cas_latency != `CASL_FLASH_RSVD);
            end
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    function automatic sxmem_timing_pkg::mem_req_t build_req(sxmem_timing_pkg::cfg_t c,
                                                             sxmem_timing_pkg::req_word_t w, logic half);
        sxmem_timing_pkg::mem_req_t r;
        r.half = half;
        r.part = w.part;
        // Flash runs with the field ignored, one slot between commands
        if (c.memory_type == `TYPE_FLASH) begin
            r.row_cyc = `ROWL_FLASH_CYC;
        end else if (c.row_latency == `ROWL_CODE_LONG) begin
            r.row_cyc = `ROWL_LONG_CYC;
        end else begin
            r.row_cyc = {1'b0, c.row_latency} + 4'h1;
        end
        r.cas_cyc = {1'b0, c.cas_latency} + 4'h1;
        r.row = w.row & ((c.row_width == `ROWW_13) ? `ROW_MASK_13 : `ROW_MASK_12);
        unique case (c.column_width)
            2'h0: r.col = w.col & `COL_MASK_7;
            2'h1: r.col = w.col & `COL_MASK_8;
            2'h2: r.col = w.col & `COL_MASK_9;
            2'h3: r.col = w.col & `COL_MASK_10;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------------
    // System domain state
    // ------------------------------------------------------------------
    sxmem_timing_pkg::cfg_t cfg_r;
    sxmem_timing_pkg::mem_req_t req_r;
    sxmem_timing_pkg::req_word_t wword;
    sxmem_timing_pkg::status_t status;
    logic half_r;
    logic busy_r;
    logic done_r;
    logic err_r;
    logic req_tgl_r;
    logic done_s1_r;
    logic done_s2_r;
    logic done_seen_r;
    logic done_edge;
    logic [31:0] rdata_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] rd_nxt;
    logic refuse_nxt;
    logic wr_ok;
    logic req_fire;
    logic req_good;

    // Link domain state, declared here for the crossing
    logic done_tgl_r;
    logic [DQ_W-1:0] capt_r;

    assign wword = sxmem_timing_pkg::req_word_t'(PWDATA);
    assign wr_ok = PSEL & PENABLE & pready_r & PWRITE & ~pslverr_r;
    assign req_fire = wr_ok & (PADDR == `REG_REQUEST_ADDR);
    assign req_good = cfg_ok(cfg_r, wword.part);
    assign done_edge = done_s2_r ^ done_seen_r;

    // Status word assembly
    always_comb begin
        status = '0;
        status.busy = busy_r;
        status.done = done_r;
        status.err = err_r;
        status.rl_warn = (cfg_r.memory_type == `TYPE_FLASH) && (cfg_r.row_latency != `ROWL_CODE_LONG);
    end

    // Read mux and refusal decision
    always_comb begin
        rd_nxt = 32'h0;
        refuse_nxt = 1'b0;
        unique case (PADDR)
            `REG_CONFIG_ADDR: begin
                rd_nxt = cfg_r;
                refuse_nxt = PWRITE & busy_r;
            end
            `REG_CTRL_ADDR: begin
                rd_nxt = {31'h0, half_r};
                refuse_nxt = PWRITE & busy_r;
            end
            `REG_REQUEST_ADDR: begin
                refuse_nxt = PWRITE & busy_r;
            end
            `REG_STATUS_ADDR: rd_nxt = status;
            `REG_RDATA_ADDR: rd_nxt = rdata_r;
            default: refuse_nxt = 1'b1;
        endcase
    end

    // APB answer: one wait state, all outputs registered
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0;
        end else begin
            pready_r <= PSEL & PENABLE & ~pready_r;
            pslverr_r <= PSEL & PENABLE & ~pready_r & refuse_nxt;
            prdata_r <= (PSEL & PENABLE & ~pready_r & ~PWRITE) ? rd_nxt : 32'h0;
        end
    end

    // Config and control writes; frozen while a read is in flight
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            cfg_r <= `CONFIG_RESET;
            half_r <= 1'b0;
        end else if (wr_ok) begin
            if (PADDR == `REG_CONFIG_ADDR) begin
                cfg_r <= PWDATA & `CONFIG_WMASK;
            end
            if (PADDR == `REG_CTRL_ADDR) begin
                half_r <= PWDATA[0];
            end
        end
    end

    // Request launch and status flags
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
            err_r <= 1'b0;
            req_tgl_r <= 1'b0;
            req_r <= '0;
        end else begin
            if (done_edge) begin
                busy_r <= 1'b0;
                done_r <= 1'b1;
            end
            if (req_fire && req_good) begin
                busy_r <= 1'b1;
                done_r <= 1'b0;
                err_r <= 1'b0;
                req_tgl_r <= ~req_tgl_r;
                req_r <= build_req(cfg_r, wword, half_r);
            end else if (req_fire) begin
                err_r <= 1'b1;
            end
        end
    end

    // Done toggle back from the link; data is stable once it arrives
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            done_s1_r <= 1'b0;
            done_s2_r <= 1'b0;
            done_seen_r <= 1'b0;
            rdata_r <= 32'h0;
        end else begin
            done_s1_r <= done_tgl_r;
            done_s2_r <= done_s1_r;
            done_seen_r <= done_s2_r;
            if (done_edge) begin
                rdata_r <= 32'(capt_r);
            end
        end
    end

    assign PRDATA = prdata_r;
    assign PREADY = pready_r;
    assign PSLVERR = pslverr_r;

    // ------------------------------------------------------------------
    // Link domain
    // ------------------------------------------------------------------
    sxmem_timing_pkg::link_state_t state_r;
    sxmem_timing_pkg::mem_req_t cur_r;
    logic lrst_s1_r;
    logic lrst_s2_r;
    logic req_s1_r;
    logic req_s2_r;
    logic req_seen_r;
    logic phase_r;
    logic tick;
    logic [3:0] cnt_r;
    logic [1:0] lag_r;
    logic [1:0] cmd_r;
    logic [12:0] addr_r;
    logic [1:0] cs_n_r;
    logic clk_half_r;
    logic due_r;
    logic [DQ_W-1:0] dq_s1_r;
    logic [DQ_W-1:0] dq_s2_r;

    // Reset release aligned to the link clock
    always_ff @(posedge LINK_CLK or negedge RSTN) begin
        if (!RSTN) begin
            lrst_s1_r <= 1'b0;
            lrst_s2_r <= 1'b0;
        end else begin
            lrst_s1_r <= 1'b1;
            lrst_s2_r <= lrst_s1_r;
        end
    end

    // Request toggle and data pins, two flops each
    always_ff @(posedge LINK_CLK or negedge lrst_s2_r) begin
        if (!lrst_s2_r) begin
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
            dq_s1_r <= '0;
            dq_s2_r <= '0;
        end else begin
            req_s1_r <= req_tgl_r;
            req_s2_r <= req_s1_r;
            dq_s1_r <= MEM_DQ;
            dq_s2_r <= dq_s1_r;
        end
    end

    // Half rate: a latency slot is every second memory clock
    assign tick = ~cur_r.half | phase_r;

    // Read sequencer
    always_ff @(posedge LINK_CLK or negedge lrst_s2_r) begin
        if (!lrst_s2_r) begin
            state_r <= sxmem_timing_pkg::L_IDLE;
            cur_r <= '0;
            req_seen_r <= 1'b0;
            phase_r <= 1'b0;
            cnt_r <= 4'h0;
            lag_r <= 2'h0;
            cmd_r <= `CMD_NOP;
            addr_r <= 13'h0;
            cs_n_r <= 2'h3;
            due_r <= 1'b0;
            capt_r <= '0;
            done_tgl_r <= 1'b0;
        end else begin
            phase_r <= (state_r == sxmem_timing_pkg::L_IDLE) ? 1'b0 : ~phase_r;
            due_r <= 1'b0;
            unique case (state_r)
                sxmem_timing_pkg::L_IDLE: begin
                    if (req_s2_r != req_seen_r) begin
                        req_seen_r <= req_s2_r;
                        cur_r <= req_r;
                        state_r <= sxmem_timing_pkg::L_ACT;
                    end
                end
                sxmem_timing_pkg::L_ACT: begin
                    if (tick) begin
                        cmd_r <= `CMD_ACT;
                        addr_r <= cur_r.row;
                        cs_n_r <= cur_r.part ? 2'h1 : 2'h2;
                        cnt_r <= cur_r.row_cyc - 4'h1;
                        state_r <= sxmem_timing_pkg::L_ROW_WAIT;
                    end
                end
                sxmem_timing_pkg::L_ROW_WAIT: begin
                    if (tick && cnt_r == 4'h0) begin
                        cmd_r <= `CMD_READ;
                        addr_r <= {3'h0, cur_r.col};
                        cnt_r <= cur_r.cas_cyc - 4'h1;
                        state_r <= sxmem_timing_pkg::L_CAS_WAIT;
                    end else if (tick) begin
                        cmd_r <= `CMD_NOP;
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                sxmem_timing_pkg::L_CAS_WAIT: begin
                    if (tick) begin
                        cmd_r <= `CMD_NOP;
                        cnt_r <= cnt_r - 4'h1;
                        if (cnt_r == 4'h0) begin
                            due_r <= 1'b1;
                            lag_r <= `SYNC_LAG_CYC;
                            state_r <= sxmem_timing_pkg::L_CAPT;
                        end
                    end
                end
                sxmem_timing_pkg::L_CAPT: begin
                    // Pin data reaches the second sync flop two clocks late
                    lag_r <= lag_r - 2'h1;
                    if (lag_r == 2'h1) begin
                        capt_r <= dq_s2_r;
                        state_r <= sxmem_timing_pkg::L_DONE;
                    end
                end
                sxmem_timing_pkg::L_DONE: begin
                    cs_n_r <= 2'h3;
                    done_tgl_r <= ~done_tgl_r;
                    state_r <= sxmem_timing_pkg::L_IDLE;
                end
                default: state_r <= sxmem_timing_pkg::L_IDLE;
            endcase
        end
    end

    // Divided clock shown only in half rate; full rate uses LINK_CLK itself
    always_ff @(posedge LINK_CLK or negedge lrst_s2_r) begin
        if (!lrst_s2_r) begin
            clk_half_r <= 1'b0;
        end else begin
            clk_half_r <= cur_r.half & (state_r != sxmem_timing_pkg::L_IDLE) & ~phase_r;
        end
    end

    assign MEM_CMD = cmd_r;
    assign MEM_ADDR = addr_r;
    assign MEM_CS_N = cs_n_r;
    assign MEM_CLK_HALF = clk_half_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [1:0] prev_cmd_r;
    logic [5:0] act_gap_r;
    logic [5:0] rd_gap_r;
    logic [4:0] row_span;
    logic [4:0] cas_span;

    // Gap counters measured on the command pins
    always_ff @(posedge LINK_CLK or negedge lrst_s2_r) begin
        if (!lrst_s2_r) begin
            prev_cmd_r <= `CMD_NOP;
            act_gap_r <= 6'h0;
            rd_gap_r <= 6'h0;
        end else begin
            prev_cmd_r <= cmd_r;
            act_gap_r <= (cmd_r == `CMD_ACT && prev_cmd_r != `CMD_ACT) ? 6'h1 : act_gap_r + 6'h1;
            rd_gap_r <= (cmd_r == `CMD_READ && prev_cmd_r != `CMD_READ) ? 6'h1 : rd_gap_r + 6'h1;
        end
    end

    assign row_span = cur_r.half ? {cur_r.row_cyc, 1'b0} : {1'b0, cur_r.row_cyc};
    assign cas_span = cur_r.half ? {cur_r.cas_cyc, 1'b0} : {1'b0, cur_r.cas_cyc};

    a_row_gap_count: assert property (@(posedge LINK_CLK) disable iff (!lrst_s2_r)
        (cmd_r == `CMD_READ && prev_cmd_r != `CMD_READ) |-> act_gap_r == {1'b0, row_span})
        else $error("ACT to READ spacing wrong");

    a_cas_gap_count: assert property (@(posedge LINK_CLK) disable iff (!lrst_s2_r)
        due_r |-> rd_gap_r == {1'b0, cas_span})
        else $error("READ to data spacing wrong");

    a_half_rate_slots: assert property (@(posedge LINK_CLK) disable iff (!lrst_s2_r)
        (cur_r.half && state_r != sxmem_timing_pkg::L_IDLE && tick) |=> !tick)
        else $error("Half rate slot not stretched");

    a_rom_row_map: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        (req_fire && req_good && cfg_r.memory_type == `TYPE_MASK_ROM) |=>
        req_r.row_cyc == (($past(cfg_r.row_latency) == `ROWL_CODE_LONG) ? `ROWL_LONG_CYC :
                          {1'b0, $past(cfg_r.row_latency)} + 4'h1))
        else $error("Mask ROM row latency decode wrong");

    a_flash_row_ignored: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        (req_fire && req_good && cfg_r.memory_type == `TYPE_FLASH) |=> req_r.row_cyc == `ROWL_FLASH_CYC)
        else $error("Flash row latency not ignored");

    a_rom_cas_reserved: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        (req_fire && cfg_r.memory_type == `TYPE_MASK_ROM &&
         (cfg_r.cas_latency < `CASL_MIN_CODE || cfg_r.cas_latency == `CASL_ROM_RSVD)) |=> err_r && !busy_r)
        else $error("Reserved mask ROM CAS code accepted");

    a_flash_cas_map: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        (req_fire && cfg_r.memory_type == `TYPE_FLASH) |=>
        ($past(cfg_r.cas_latency) == `CASL_FLASH_RSVD) ? err_r :
        (!$past(req_good) || req_r.cas_cyc == {1'b0, $past(cfg_r.cas_latency)} + 4'h1))
        else $error("Flash CAS decode wrong");

    a_type_reserved: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        (req_fire && cfg_r.memory_type[0]) |=> err_r && !busy_r)
        else $error("Reserved memory type accepted");

    a_row_width_mask: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        (req_fire && req_good && cfg_r.row_width == `ROWW_12) |=> !req_r.row[12])
        else $error("Row address above width");

    a_config_readback: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        (wr_ok && PADDR == `REG_CONFIG_ADDR) |=> cfg_r == ($past(PWDATA) & `CONFIG_WMASK))
        else $error("Config word layout wrong");

    c_rom_read: cover property (@(posedge CLK_SYS) disable iff (!RSTN)
        done_edge && cfg_r.memory_type == `TYPE_MASK_ROM);
    c_flash_read: cover property (@(posedge CLK_SYS) disable iff (!RSTN)
        done_edge && cfg_r.memory_type == `TYPE_FLASH);
    c_half_read: cover property (@(posedge LINK_CLK) disable iff (!lrst_s2_r)
        due_r && cur_r.half);
    c_refused: cover property (@(posedge CLK_SYS) disable iff (!RSTN)
        req_fire && !req_good);

endmodule // sync_static_mem_timing_cfg

`default_nettype wire

/* dv/sx_mem_model.sv */
/*
 Behavioural synchronous memory on the link side of the timing block.
 Assumes link commands and the expected CAS span in link clock cycles.
*/
`timescale 1ns/1ns
`default_nettype none
`include "sxmem_timing_consts.svh"
module sx_mem_model (
    input wire logic clk,
    input wire logic [1:0] cmd,
    input wire logic [31:0] data,
    input wire logic [7:0] cas,
    output logic [31:0] dq,
    output logic [7:0] gap
);
    logic [7:0] n = 8'h00;
    logic [1:0] pc = 2'h0;
    initial gap = 8'h00;
    initial dq = 32'h00000000;
    // ---------------------------------------------
    // Command spacing and data launch
    // ---------------------------------------------
    // Data valid only in a short window; inverted outside so late capture shows
    always @(posedge clk) begin
        pc <= cmd;
        n <= n + 8'h01;
        dq <= (n + 8'h02 >= cas && n <= cas) ? data : ~data;
        if (cmd == `CMD_ACT && pc != `CMD_ACT) n <= 8'h01;
        if (cmd == `CMD_READ && pc != `CMD_READ) begin
            gap <= n;
            n <= 8'h01;
        end
    end
endmodule // sx_mem_model
`default_nettype wire

/* dv/tb_sync_static_mem_timing_cfg.sv */
/*
 Self-checking bench for the memory timing block over APB.
 Assumes the design sources and the memory model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "sxmem_timing_consts.svh"
module tb_sync_static_mem_timing_cfg;
    logic CLK_SYS = 0, LINK_CLK = 0, RSTN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic [31:0] PADDR = 0, PWDATA = 0, PRDATA, dq, rd;
    logic PREADY, PSLVERR, MEM_CLK_HALF, er;
    logic [1:0] MEM_CMD, MEM_CS_N;
    logic [12:0] MEM_ADDR;
    logic [7:0] cas = 0, gap;
    int fail_count = 0, n_tests = 0;
    localparam logic [31:0] PAT = 32'h5a3c96e1;
    // ---------------------------------------------
    // Clocks and instances
    // ---------------------------------------------
    initial begin
        forever #5 CLK_SYS = ~CLK_SYS;
    end
    initial begin
        #3;
        forever #6 LINK_CLK = ~LINK_CLK;
    end
    sync_static_mem_timing_cfg i_sync_static_mem_timing_cfg (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
        .LINK_CLK(LINK_CLK), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .MEM_CMD(MEM_CMD),
        .MEM_ADDR(MEM_ADDR), .MEM_CS_N(MEM_CS_N), .MEM_CLK_HALF(MEM_CLK_HALF), .MEM_DQ(dq));
    sx_mem_model i_sx_mem_model (.clk(LINK_CLK), .cmd(MEM_CMD), .data(PAT), .cas(cas), .dq(dq),
        .gap(gap));
    // ---------------------------------------------
    // Bus and compare tasks
    // ---------------------------------------------
    // Request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge CLK_SYS);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK_SYS);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLK_SYS);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Polls status; bounded so a stuck engine cannot hang the run
    task automatic rq(input logic [31:0] c, input logic h);
        int n;
        n = 0;
        apb(1'b1, `REG_CTRL_ADDR, {31'h0, h});
        apb(1'b1, `REG_CONFIG_ADDR, c);
        apb(1'b1, `REG_REQUEST_ADDR, 32'h0000a123);
        do begin
            apb(1'b0, `REG_STATUS_ADDR, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 60);
    endtask
    task automatic rd_chk(input logic [31:0] c, input logic h, input logic [7:0] rl, input logic [7:0] cl);
        cas <= h ? cl * 8'h02 : cl;
        rq(c, h);
        chk(rd, 32'h2);
        apb(1'b0, `REG_RDATA_ADDR, 32'h0);
        chk(rd, PAT);
        chk({24'h0, gap}, {24'h0, h ? rl * 8'h02 : rl});
        // Idle pins after a read: chips released, column 5 of the request still on the bus
        chk({16'h0, MEM_CLK_HALF, MEM_CS_N, MEM_ADDR}, {16'h0, 1'b0, 2'h3, 13'h0005});
    endtask
    // ---------------------------------------------
    // Scenarios
    // ---------------------------------------------
    task automatic t_regs;
        apb(1'b0, `REG_CONFIG_ADDR, 32'h0);
        chk(rd, `CONFIG_RESET);
        apb(1'b1, `REG_CONFIG_ADDR, 32'hffffffff);
        apb(1'b0, `REG_CONFIG_ADDR, 32'h0);
        chk(rd, `CONFIG_WMASK);
        apb(1'b0, 32'h48000100, 32'h0);
        chk({31'h0, er}, 32'h1);
    endtask
    // Reserved CAS, type, row width and row codes, then disabled partition
    task automatic t_refuse;
        logic [31:0] bad [10];
        bad = '{32'h1, 32'h5, 32'h19, 32'h2001, 32'h2005, 32'h201d, 32'h1009, 32'h209, 32'hc9, 32'h8};
        foreach (bad[i]) begin
            rq(bad[i], 1'b0);
            chk(rd & 32'h5, 32'h4);
        end
    endtask
    task automatic t_rom;
        rd_chk(32'h29, 1'b0, 8'd2, 8'd3);
        rd_chk(32'hf5, 1'b0, 8'd8, 8'd6);
    endtask
    task automatic t_flash;
        rd_chk(32'h20f1, 1'b0, 8'd1, 8'd5);
        // Flash with a row field other than 111 is flagged in status
        apb(1'b1, `REG_CONFIG_ADDR, 32'h2031);
        apb(1'b0, `REG_STATUS_ADDR, 32'h0);
        chk(rd & 32'h8, 32'h8);
    endtask
    // Half rate, plus a config write refused while busy
    task automatic t_half;
        rd_chk(32'h2d, 1'b1, 8'd2, 8'd4);
        apb(1'b1, `REG_REQUEST_ADDR, 32'h0000a123);
        apb(1'b1, `REG_CONFIG_ADDR, 32'h0);
        chk({31'h0, er}, 32'h1);
    endtask
    // ---------------------------------------------
    // Sequence, watchdog and verdict
    // ---------------------------------------------
    task automatic print_verdict;
        if (fail_count == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge CLK_SYS);
        RSTN <= 1'b1;
        repeat (8) @(posedge CLK_SYS);
        t_regs;
        t_refuse;
        t_rom;
        t_flash;
        t_half;
        print_verdict;
    end
    initial begin
        #300000;
        fail_count++;
        print_verdict;
    end
endmodule // tb_sync_static_mem_timing_cfg
`default_nettype wire
